//--- bench/pfmt_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfmt_phy_model (
  input wire logic hclk,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [31:0] tx_quadlet,
  input wire logic tx_last,
  output logic tx_ready,
  output logic rx_begin,
  output logic rx_is_selfid,
  output logic rx_valid,
  output logic [31:0] rx_quadlet,
  output logic rx_done,
  output logic [1:0] rx_error,
  input wire logic rx_ready
);
  logic [32:0] got[$];
  initial
  begin
    {rx_begin, rx_is_selfid, rx_valid, rx_done, rx_error} = 6'h0;
    rx_quadlet = 32'h0;
  end
  // Collect quadlets, stall on request
  always @(posedge hclk)
  begin
    if (tx_valid && tx_ready)
      got.push_back({tx_last, tx_quadlet});
    tx_ready <= !stall;
  end
  // Hold strobe until taken, then scramble data lines
  task automatic hold(input logic [31:0] q);
    rx_quadlet <= q;
    do @(posedge hclk); while (rx_ready !== 1'b1);
    {rx_begin, rx_valid} <= 2'h0;
    rx_quadlet <= ~q;
  endtask : hold
  // One to three self-IDs at base rate, or a two-quadlet PHY packet
  task automatic send(input logic sid, input logic [31:0] q0, input logic [31:0] q1,
    input int n, input logic [1:0] err);
    @(posedge hclk);
    rx_begin <= 1'b1;
    rx_is_selfid <= sid;
    hold(~rx_quadlet);
    for (int i = 0; i < n; i++)
    begin
      @(posedge hclk);
      rx_valid <= 1'b1;
      hold(i == 1 ? q1 : q0 + i);
    end
    @(posedge hclk);
    rx_done <= 1'b1;
    rx_error <= err;
    @(posedge hclk);
    rx_done <= 1'b0;
    rx_error <= ~err;
  endtask : send
endmodule : pfmt_phy_model
`default_nettype wire

//--- bench/pfmt_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pfmt_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [31:0] tx_quadlet,
  input wire logic tx_last,
  input wire logic rx_begin,
  input wire logic rx_is_selfid,
  input wire logic rx_valid,
  input wire logic [31:0] rx_quadlet,
  input wire logic rx_done,
  input wire logic [1:0] rx_error,
  input wire logic rx_ready,
  input wire logic header_error
);
  logic take;
  logic wr_stat;
  logic commit_ph;
  logic [1:0] txn;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  assign take = hsel && htrans[1] && hready;
  assign wr_stat = take && hwrite && haddr[7:0] == pfmt_pkg::ADDR_STATUS;
  // Commit write in its data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      commit_ph <= 1'b0;
    else if (hready)
      commit_ph <= take && hwrite && haddr[7:0] == pfmt_pkg::ADDR_TX_COMMIT;
  // Quadlets handed over in the current packet
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      txn <= 2'h0;
    else if (tx_valid && tx_ready)
      txn <= tx_last ? 2'h0 : txn + 2'h1;
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  chk_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_quadlet) && $stable(tx_last))
    else $error("tx changed while stalled");
  chk_commit_start: assert property (commit_ph && hready |-> ##[1:3] tx_valid)
    else $error("commit did not start tx");
  chk_last_third: assert property (
    tx_valid && tx_ready |-> tx_last == (txn == 2'h2))
    else $error("tx_last not on third quadlet");
  chk_hdr_cause: assert property (
    $rose(header_error) |-> $past(rx_valid) || $past(rx_valid, 2) || $past(rx_valid, 3))
    else $error("header error without rx data");
  chk_hdr_clear: assert property (
    $fell(header_error) |-> $past(wr_stat) || $past(wr_stat, 2) || $past(wr_stat, 3))
    else $error("header error cleared without write");
  chk_read_answer: assert property (take && !hwrite |=> hreadyout)
    else $error("read got wait state");
  chk_write_answer: assert property (take && hwrite && !haddr[7] |=> hreadyout)
    else $error("register write got wait state");
  chk_rdata_hold: assert property (!$stable(hrdata) |-> $past(take && !hwrite))
    else $error("hrdata changed without read");
endmodule : pfmt_checker
bind pfmt_top pfmt_checker u_pfmt_checker (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .tx_valid, .tx_ready,
  .tx_quadlet, .tx_last, .rx_begin, .rx_is_selfid, .rx_valid, .rx_quadlet, .rx_done,
  .rx_error, .rx_ready, .header_error);
`default_nettype wire

//--- bench/pfmt_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pfmt_top_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_valid, tx_ready, tx_last;
  logic rx_begin, rx_is_selfid, rx_valid, rx_done, rx_ready, header_error, stall;
  logic [31:0] haddr, hwdata, hrdata, tx_quadlet, rx_quadlet, rd, q0;
  logic [1:0] htrans, rx_error;
  int errors, n_tests;
  localparam logic [15:0] DEST = 16'hFFC5;
  localparam logic [31:0] CFG_BODY = 32'h00C0_3F00;
  localparam logic [31:0] LINK_BODY = 32'h4500_0000;
  pfmt_top u_pfmt_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tx_valid, .tx_ready,
    .tx_quadlet, .tx_last, .rx_begin, .rx_is_selfid, .rx_valid, .rx_quadlet, .rx_done,
    .rx_error, .rx_ready, .header_error);
  pfmt_phy_model u_pfmt_phy_model (.hclk, .stall, .tx_valid, .tx_quadlet, .tx_last,
    .tx_ready, .rx_begin, .rx_is_selfid, .rx_valid, .rx_quadlet, .rx_done, .rx_error,
    .rx_ready);
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic stop_test;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One single AHB-Lite transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic txpkt(input logic [31:0] body);
    ahb(1'b1, pfmt_pkg::ADDR_TX_FIRST, pfmt_pkg::TX_HEADER_QUAD);
    ahb(1'b1, pfmt_pkg::ADDR_TX_CONTINUE, body);
    ahb(1'b1, pfmt_pkg::ADDR_TX_COMMIT, ~body);
  endtask : txpkt
  task automatic txchk(input logic [31:0] body);
    for (int i = 0; i < 60 && u_pfmt_phy_model.got.size() < 3; i++)
      @(posedge hclk);
    chk(u_pfmt_phy_model.got.pop_front(), {1'b0, pfmt_pkg::TX_HEADER_QUAD});
    chk(u_pfmt_phy_model.got.pop_front(), {1'b0, body});
    chk(u_pfmt_phy_model.got.pop_front(), {1'b1, ~body});
  endtask : txchk
  task automatic unstall;
    repeat (30) @(posedge hclk);
    stall <= 1'b0;
  endtask : unstall
  function automatic logic [31:0] tok(input logic [7:0] n, input logic [3:0] st);
    tok = 32'h0;
    tok[pfmt_pkg::TOK_TRANS_CODE_LSB +: 4] = pfmt_pkg::TRANS_CODE_SELFID;
    tok[pfmt_pkg::TOK_COUNT_LSB +: 8] = n;
    tok[pfmt_pkg::TOK_SPD_LSB +: 2] = pfmt_pkg::SPD_S100;
    tok[pfmt_pkg::TOK_PKT_DONE_BIT] = 1'b1;
    tok[pfmt_pkg::TOK_STATUS_LSB +: 4] = st;
  endfunction : tok
  // Watchdog, several times the expected run
  initial
  begin
    #20000;
    errors++;
    stop_test;
  end
  initial
  begin
    {errors, n_tests} = 0;
    {hresetn, hsel, hwrite, htrans, stall} = 6'h0;
    {haddr, hwdata} = 64'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(pfmt_pkg::ADDR_CTRL, pfmt_pkg::CTRL_RESET);
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0);
    rdc(pfmt_pkg::ADDR_RXF_READ, 32'h0);
    $display("test registers done");
    stall <= 1'b1;
    txpkt(CFG_BODY);
    fork
      unstall();
      txpkt(LINK_BODY);
    join
    txchk(CFG_BODY);
    txchk(LINK_BODY);
    $display("test transmit done");
    ahb(1'b1, pfmt_pkg::ADDR_CTRL, {DEST, 16'h0001});
    for (int e = 0; e < 3; e++)
    begin
      q0 = 32'h8A00_0000 | e;
      u_pfmt_phy_model.send(1'b1, q0, q0 + 1, e + 1, 2'(e));
      rdc(pfmt_pkg::ADDR_STATUS, 32'(e + 2) << pfmt_pkg::STAT_COUNT_LSB);
      rdc(pfmt_pkg::ADDR_RXF_READ, tok(8'(e + 1), e == 0 ? pfmt_pkg::RS_COMPLETE :
        e == 1 ? pfmt_pkg::RS_DATA_ERROR : pfmt_pkg::RS_CRC_ERROR));
      for (int i = 0; i <= e; i++)
        rdc(pfmt_pkg::ADDR_RXF_READ, q0 + i);
    end
    ahb(1'b1, pfmt_pkg::ADDR_CTRL, {DEST, 16'h0000});
    u_pfmt_phy_model.send(1'b1, 32'h1, 32'h2, 2, 2'h0);
    rdc(pfmt_pkg::ADDR_RXF_READ, 32'h0);
    $display("test self-id done");
    u_pfmt_phy_model.send(1'b0, 32'h0040_5678, 32'h0, 2, 2'h0);
    rdc(pfmt_pkg::ADDR_RXF_READ, 32'h0);
    u_pfmt_phy_model.send(1'b0, 32'h0040_1234, ~32'h0040_1234, 2, 2'h0);
    rdc(pfmt_pkg::ADDR_RXF_READ, tok(8'h01, pfmt_pkg::RS_PHY_PACKET));
    rdc(pfmt_pkg::ADDR_RXF_READ, 32'h0040_1234);
    chk(header_error, 1'b0);
    u_pfmt_phy_model.send(1'b0, {DEST, 16'h0042}, ~{DEST, 16'h0042}, 2, 2'h0);
    rdc(pfmt_pkg::ADDR_RXF_READ, tok(8'h01, pfmt_pkg::RS_PHY_PACKET));
    rdc(pfmt_pkg::ADDR_RXF_READ, {DEST, 16'h0042});
    chk(header_error, 1'b1);
    ahb(1'b1, pfmt_pkg::ADDR_STATUS, 32'h1);
    rdc(pfmt_pkg::ADDR_STATUS, 32'h0);
    $display("test phy packet done");
    stop_test;
  end
endmodule : pfmt_top_tb
`default_nettype wire

//--- include/pfmt_pkg.sv
package pfmt_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RXF_READ = 8'h08;
  localparam logic [7:0] ADDR_TX_FIRST = 8'h80;
  localparam logic [7:0] ADDR_TX_CONTINUE = 8'h84;
  localparam logic [7:0] ADDR_TX_COMMIT = 8'h8C;
  // Control fields
  localparam int CTRL_SID_EN_BIT = 0;
  localparam int CTRL_DEST_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status fields
  localparam int STAT_HDR_ERR_BIT = 0;
  localparam int STAT_TX_BUSY_BIT = 1;
  localparam int STAT_COUNT_LSB = 8;
  // Transmit header quadlet for unformatted packets
  localparam logic [31:0] TX_HEADER_QUAD = 32'h0000_00E0;
  localparam int TX_SLOTS = 4;
  // Receive token layout
  localparam int TOK_TRANS_CODE_LSB = 4;
  localparam int TOK_COUNT_LSB = 24;
  localparam int TOK_SPD_LSB = 16;
  localparam int TOK_PKT_DONE_BIT = 11;
  localparam int TOK_STATUS_LSB = 12;
  localparam logic [3:0] TRANS_CODE_SELFID = 4'hE;
  // Speed codes
  localparam logic [1:0] SPD_S100 = 2'h0;
  localparam logic [1:0] SPD_S200 = 2'h1;
  localparam logic [1:0] SPD_S400 = 2'h2;
  // Receive status codes
  localparam logic [3:0] RS_PHY_PACKET = 4'h0;
  localparam logic [3:0] RS_COMPLETE = 4'h1;
  localparam logic [3:0] RS_DATA_ERROR = 4'hD;
  localparam logic [3:0] RS_CRC_ERROR = 4'hF;
  // Link-side error report
  localparam logic [1:0] LERR_NONE = 2'h0;
  localparam logic [1:0] LERR_DATA = 2'h1;
  // General receive FIFO
  localparam int RXF_AW = 5;
  localparam int RXF_DEPTH = 32;
  localparam logic [RXF_AW:0] RXF_READY_SPACE = 6'h03;

  typedef enum logic [1:0] {
    PFMT_RX_IDLE = 2'b00,
    PFMT_RX_SELFID = 2'b01,
    PFMT_RX_PHY_FIRST = 2'b10,
    PFMT_RX_PHY_CHECK = 2'b11
  } pfmt_rx_state_t;
endpackage : pfmt_pkg

//--- verilog/pfmt_buf2.sv
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer, head always in slot 0
module pfmt_buf2 #(
  parameter int W = 33
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] slot1;
  logic full;
  logic push;
  logic pop;

  assign in_ready = ~full;
  assign push = in_valid & ~full;
  assign pop = out_valid & out_ready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_valid <= 1'b0;
      full <= 1'b0;
      out_data <= '0;
      slot1 <= '0;
    end
    else if (pop)
    begin
      if (full)
      begin
        out_data <= slot1;
        full <= 1'b0;
      end
      else
      begin
        out_data <= in_data;
        out_valid <= push;
      end
    end
    else if (push)
    begin
      if (!out_valid)
      begin
        out_data <= in_data;
        out_valid <= 1'b1;
      end
      else
      begin
        slot1 <= in_data;
        full <= 1'b1;
      end
    end
  end
endmodule : pfmt_buf2
`default_nettype wire

//--- verilog/pfmt_top.sv
`timescale 1ns/1ps
`default_nettype none
module pfmt_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [31:0] tx_quadlet,
  output logic tx_last,
  input wire logic rx_begin,
  input wire logic rx_is_selfid,
  input wire logic rx_valid,
  input wire logic [31:0] rx_quadlet,
  input wire logic rx_done,
  input wire logic [1:0] rx_error,
  output logic rx_ready,
  output logic header_error
);
  // Bus data phase
  logic dph_valid;
  logic dph_write;
  logic [7:0] dph_addr;
  logic accept;
  logic wr_do;
  logic commit_now;
  logic is_tx_addr;
  // Control and status
  logic sid_enable;
  logic [15:0] local_dest_id;
  // Transmit staging
  logic [31:0] tx_mem [0:pfmt_pkg::TX_SLOTS-1];
  logic [1:0] tx_wr_idx;
  logic [1:0] tx_len_m1;
  logic [1:0] tx_rd_idx;
  logic tx_busy;
  logic buf_in_ready;
  logic drain_push;
  // Receive FIFO
  logic [31:0] rxf_mem [0:pfmt_pkg::RXF_DEPTH-1];
  logic [pfmt_pkg::RXF_AW:0] rxf_wr_ptr;
  logic [pfmt_pkg::RXF_AW:0] rxf_commit_ptr;
  logic [pfmt_pkg::RXF_AW:0] rxf_rd_ptr;
  logic [pfmt_pkg::RXF_AW:0] rxf_token_ptr;
  logic [pfmt_pkg::RXF_AW:0] rxf_count;
  logic [pfmt_pkg::RXF_AW:0] rxf_space;
  logic rxf_pop;
  logic [7:0] sid_count;
  logic [31:0] phy_first;
  pfmt_pkg::pfmt_rx_state_t rx_state;
  logic rx_take;
  logic rx_begin_take;
  logic phy_ok;
  logic hdr_hit;
  logic [3:0] sid_status;
  logic [31:0] sid_token;
  logic [31:0] phy_token;

  assign accept = hsel & htrans[1] & hready;
  assign wr_do = dph_valid & dph_write & hreadyout;
  assign commit_now = wr_do & (dph_addr == pfmt_pkg::ADDR_TX_COMMIT);
  assign is_tx_addr = (haddr[7:0] == pfmt_pkg::ADDR_TX_FIRST)
    | (haddr[7:0] == pfmt_pkg::ADDR_TX_CONTINUE)
    | (haddr[7:0] == pfmt_pkg::ADDR_TX_COMMIT);
  assign rxf_count = rxf_commit_ptr - rxf_rd_ptr;
  assign rxf_space = 6'(pfmt_pkg::RXF_DEPTH) - (rxf_wr_ptr - rxf_rd_ptr);
  assign rxf_pop = accept & ~hwrite & (haddr[7:0] == pfmt_pkg::ADDR_RXF_READ)
    & (rxf_count != '0);
  assign rx_take = rx_valid & rx_ready;
  assign rx_begin_take = rx_begin & rx_ready;
  assign phy_ok = (rx_quadlet == ~phy_first);
  assign hdr_hit = (rx_quadlet[31:16] == local_dest_id);

  // Bus address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr <= 8'h00;
    end
    else if (accept)
    begin
      dph_valid <= 1'b1;
      dph_write <= hwrite;
      dph_addr <= haddr[7:0];
    end
    else if (hreadyout)
    begin
      dph_valid <= 1'b0;
    end
  end

  // Wait states while a committed packet is still draining
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
    end
    else if (accept && hwrite && is_tx_addr && (tx_busy || commit_now))
    begin
      hreadyout <= 1'b0;
    end
    else if (!hreadyout && !tx_busy)
    begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
    end
  end

  // Read data, valid in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (accept && !hwrite)
    begin
      hrdata <= 32'h0000_0000;
      unique case (haddr[7:0])
        pfmt_pkg::ADDR_CTRL:
        begin
          hrdata[pfmt_pkg::CTRL_SID_EN_BIT] <= sid_enable;
          hrdata[pfmt_pkg::CTRL_DEST_LSB +: 16] <= local_dest_id;
        end
        pfmt_pkg::ADDR_STATUS:
        begin
          hrdata[pfmt_pkg::STAT_HDR_ERR_BIT] <= header_error;
          hrdata[pfmt_pkg::STAT_TX_BUSY_BIT] <= tx_busy;
          hrdata[pfmt_pkg::STAT_COUNT_LSB +: 6] <= rxf_count;
        end
        pfmt_pkg::ADDR_RXF_READ:
        begin
          if (rxf_count != '0)
          begin
            hrdata <= rxf_mem[rxf_rd_ptr[pfmt_pkg::RXF_AW-1:0]];
          end
        end
        default:
        begin
          hrdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sid_enable <= pfmt_pkg::CTRL_RESET[pfmt_pkg::CTRL_SID_EN_BIT];
      local_dest_id <= pfmt_pkg::CTRL_RESET[pfmt_pkg::CTRL_DEST_LSB +: 16];
    end
    else if (wr_do && dph_addr == pfmt_pkg::ADDR_CTRL)
    begin
      sid_enable <= hwdata[pfmt_pkg::CTRL_SID_EN_BIT];
      local_dest_id <= hwdata[pfmt_pkg::CTRL_DEST_LSB +: 16];
    end
  end

  // Header error flag, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      header_error <= 1'b0;
    end
    else if (rx_take && rx_state == pfmt_pkg::PFMT_RX_PHY_FIRST && hdr_hit)
    begin
      header_error <= 1'b1;
    end
    else if (wr_do && dph_addr == pfmt_pkg::ADDR_STATUS
      && hwdata[pfmt_pkg::STAT_HDR_ERR_BIT])
    begin
      header_error <= 1'b0;
    end
  end

  // Transmit staging: first, continue, commit locations
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_wr_idx <= 2'h0;
      tx_len_m1 <= 2'h0;
    end
    else if (wr_do && dph_addr == pfmt_pkg::ADDR_TX_FIRST)
    begin
      tx_mem[0] <= hwdata;
      tx_wr_idx <= 2'h1;
    end
    else if (wr_do && dph_addr == pfmt_pkg::ADDR_TX_CONTINUE)
    begin
      tx_mem[tx_wr_idx] <= hwdata;
      if (tx_wr_idx != 2'h3)
      begin
        tx_wr_idx <= tx_wr_idx + 2'h1;
      end
    end
    else if (commit_now)
    begin
      tx_mem[tx_wr_idx] <= hwdata;
      tx_len_m1 <= tx_wr_idx;
      tx_wr_idx <= 2'h0;
    end
  end

  // Committed packet drains into the output buffer
  assign drain_push = tx_busy & buf_in_ready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_busy <= 1'b0;
      tx_rd_idx <= 2'h0;
    end
    else if (commit_now)
    begin
      tx_busy <= 1'b1;
      tx_rd_idx <= 2'h0;
    end
    else if (drain_push)
    begin
      tx_rd_idx <= tx_rd_idx + 2'h1;
      if (tx_rd_idx == tx_len_m1)
      begin
        tx_busy <= 1'b0;
      end
    end
  end

  pfmt_buf2 #(
    .W(33)
  ) u_tx_buf (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(tx_busy),
    .in_ready(buf_in_ready),
    .in_data({tx_rd_idx == tx_len_m1, tx_mem[tx_rd_idx]}),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data({tx_last, tx_quadlet})
  );

  // Token quadlets
  always_comb
  begin
    unique case (rx_error)
      pfmt_pkg::LERR_NONE: sid_status = pfmt_pkg::RS_COMPLETE;
      pfmt_pkg::LERR_DATA: sid_status = pfmt_pkg::RS_DATA_ERROR;
      default: sid_status = pfmt_pkg::RS_CRC_ERROR;
    endcase
    sid_token = 32'h0000_0000;
    sid_token[pfmt_pkg::TOK_TRANS_CODE_LSB +: 4] = pfmt_pkg::TRANS_CODE_SELFID;
    sid_token[pfmt_pkg::TOK_PKT_DONE_BIT] = 1'b1;
    sid_token[pfmt_pkg::TOK_SPD_LSB +: 2] = pfmt_pkg::SPD_S100;
    sid_token[pfmt_pkg::TOK_COUNT_LSB +: 8] = sid_count;
    sid_token[pfmt_pkg::TOK_STATUS_LSB +: 4] = sid_status;
    phy_token = 32'h0000_0000;
    phy_token[pfmt_pkg::TOK_TRANS_CODE_LSB +: 4] = pfmt_pkg::TRANS_CODE_SELFID;
    phy_token[pfmt_pkg::TOK_PKT_DONE_BIT] = 1'b1;
    phy_token[pfmt_pkg::TOK_SPD_LSB +: 2] = pfmt_pkg::SPD_S100;
    phy_token[pfmt_pkg::TOK_COUNT_LSB +: 8] = 8'h01;
    phy_token[pfmt_pkg::TOK_STATUS_LSB +: 4] = pfmt_pkg::RS_PHY_PACKET;
  end

  // Receive framing into the general receive FIFO
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_state <= pfmt_pkg::PFMT_RX_IDLE;
      rxf_wr_ptr <= '0;
      rxf_commit_ptr <= '0;
      rxf_token_ptr <= '0;
      sid_count <= 8'h00;
      phy_first <= 32'h0000_0000;
    end
    else
    begin
      unique case (rx_state)
        pfmt_pkg::PFMT_RX_IDLE:
        begin
          if (rx_begin_take && rx_is_selfid && sid_enable)
          begin
            rxf_token_ptr <= rxf_wr_ptr;
            rxf_wr_ptr <= rxf_wr_ptr + 6'h01;
            sid_count <= 8'h00;
            rx_state <= pfmt_pkg::PFMT_RX_SELFID;
          end
          else if (rx_begin_take && !rx_is_selfid)
          begin
            rx_state <= pfmt_pkg::PFMT_RX_PHY_FIRST;
          end
        end
        pfmt_pkg::PFMT_RX_SELFID:
        begin
          if (rx_done)
          begin
            rxf_mem[rxf_token_ptr[pfmt_pkg::RXF_AW-1:0]] <= sid_token;
            rxf_commit_ptr <= rxf_wr_ptr;
            rx_state <= pfmt_pkg::PFMT_RX_IDLE;
          end
          else if (rx_take)
          begin
            rxf_mem[rxf_wr_ptr[pfmt_pkg::RXF_AW-1:0]] <= rx_quadlet;
            rxf_wr_ptr <= rxf_wr_ptr + 6'h01;
            sid_count <= sid_count + 8'h01;
          end
        end
        pfmt_pkg::PFMT_RX_PHY_FIRST:
        begin
          if (rx_done)
          begin
            rx_state <= pfmt_pkg::PFMT_RX_IDLE;
          end
          else if (rx_take)
          begin
            phy_first <= rx_quadlet;
            rx_state <= pfmt_pkg::PFMT_RX_PHY_CHECK;
          end
        end
        pfmt_pkg::PFMT_RX_PHY_CHECK:
        begin
          if (rx_done)
          begin
            rx_state <= pfmt_pkg::PFMT_RX_IDLE;
          end
          else if (rx_take)
          begin
            if (phy_ok)
            begin
              rxf_mem[rxf_wr_ptr[pfmt_pkg::RXF_AW-1:0]] <= phy_token;
              rxf_mem[5'(rxf_wr_ptr + 6'h01)] <= phy_first;
              rxf_wr_ptr <= rxf_wr_ptr + 6'h02;
              rxf_commit_ptr <= rxf_wr_ptr + 6'h02;
            end
            rx_state <= pfmt_pkg::PFMT_RX_IDLE;
          end
        end
      endcase
    end
  end

  // Read pointer and link back-pressure
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rxf_rd_ptr <= '0;
      rx_ready <= 1'b0;
    end
    else
    begin
      if (rxf_pop)
      begin
        rxf_rd_ptr <= rxf_rd_ptr + 6'h01;
      end
      rx_ready <= (rxf_space >= pfmt_pkg::RXF_READY_SPACE);
    end
  end
endmodule : pfmt_top
`default_nettype wire
